// ==== hw/mii_port_pkg.sv ====
// shared types and constants of the external mii and management port
package mii_port_pkg;

    // ------------
    // link data carriers
    // ------------
    localparam int NIBBLE_W = 4;

    typedef struct packed {
        logic                en;
        logic [NIBBLE_W-1:0] data;
    } mii_tx_t;

    typedef struct packed {
        logic                dv;
        logic                er;
        logic [NIBBLE_W-1:0] data;
    } mii_rx_t;

    localparam mii_tx_t TX_IDLE = '0;
    localparam mii_rx_t RX_IDLE = '0;

    // ------------
    // management command
    // ------------
    typedef struct packed {
        logic        write;
        logic [4:0]  phy_addr;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } mgmt_cmd_t;

    typedef enum {MGMT_IDLE, MGMT_SHIFT} mgmt_state_t;

    // ------------
    // management timing, clock period and shortest allowed mdc period
    // ------------
    localparam int         MCLK_PERIOD_NS    = 8;
    localparam int         MDC_MIN_PERIOD_NS = 400;
    localparam int         MDC_HALF_CYC      =
        (MDC_MIN_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [5:0] MDC_HALF_LAST     = 6'(MDC_HALF_CYC - 1);

    // ------------
    // management frame layout, bit 0 goes out first
    // ------------
    localparam logic [5:0]  MGMT_LAST_BIT = 6'h3f;
    localparam logic [5:0]  MGMT_TA_BIT   = 6'h2e;
    localparam logic [5:0]  MGMT_DATA_BIT = 6'h30;
    localparam logic [31:0] MGMT_PREAMBLE = 32'hffffffff;
    localparam logic [1:0]  MGMT_START    = 2'h1;
    localparam logic [1:0]  MGMT_OP_WRITE = 2'h1;
    localparam logic [1:0]  MGMT_OP_READ  = 2'h2;
    localparam logic [1:0]  MGMT_TA_DRIVE = 2'h2;
    localparam logic [1:0]  MGMT_TA_FREE  = 2'h3;

    // ------------
    // strap sampling, cycles after reset release before capture
    // ------------
    localparam logic [1:0] STRAP_SETTLE_LAST = 2'h3;

endpackage : mii_port_pkg

// ==== hw/sync_2ff.sv ====
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // destination clock
    input  wire logic             clk_i,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // no reset: the chain flushes itself in two edges
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        meta_q <= async_i;
        sync_o <= meta_q;
    end
endmodule : sync_2ff

// ==== hw/mgmt_serial.sv ====
// serial management frame engine driving mdc and mdio
`timescale 1ns/100ps
module mgmt_serial (
    // clock and control
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    input  wire logic                   enable_i,
    // command side
    input  wire logic                   start_i,
    input  wire mii_port_pkg::mgmt_cmd_t cmd_i,
    output logic                        busy_o,
    output logic                        done_o,
    output logic [15:0]                 rdata_o,
    // line side, mdio_in_i already synchronised
    input  wire logic                   mdio_in_i,
    output logic                        mdio_o,
    output logic                        mdio_oe_n_o,
    output logic                        mdc_o
);
    mii_port_pkg::mgmt_state_t state_q, state_d;
    logic [5:0]  half_q, half_d;
    logic [5:0]  bit_q, bit_d;
    logic [63:0] shift_q, shift_d;
    logic        read_q, read_d;
    logic        busy_d, done_d, mdio_d, oe_n_d, mdc_d;
    logic [15:0] rdata_d;

    always_comb begin
        state_d = state_q;
        half_d  = half_q;
        bit_d   = bit_q;
        shift_d = shift_q;
        read_d  = read_q;
        busy_d  = busy_o;
        done_d  = 1'b0;
        mdio_d  = mdio_o;
        oe_n_d  = mdio_oe_n_o;
        mdc_d   = mdc_o;
        rdata_d = rdata_o;
        case (state_q)
            mii_port_pkg::MGMT_IDLE: begin
                if (enable_i && start_i) begin
                    read_d  = !cmd_i.write;
                    shift_d = {mii_port_pkg::MGMT_PREAMBLE, mii_port_pkg::MGMT_START,
                               cmd_i.write ? mii_port_pkg::MGMT_OP_WRITE
                                           : mii_port_pkg::MGMT_OP_READ,
                               cmd_i.phy_addr, cmd_i.reg_addr,
                               cmd_i.write ? mii_port_pkg::MGMT_TA_DRIVE
                                           : mii_port_pkg::MGMT_TA_FREE,
                               cmd_i.wdata};
                    mdio_d  = 1'b1;
                    oe_n_d  = 1'b0;
                    half_d  = '0;
                    bit_d   = '0;
                    busy_d  = 1'b1;
                    state_d = mii_port_pkg::MGMT_SHIFT;
                end
            end
            mii_port_pkg::MGMT_SHIFT: begin
                half_d = half_q + 6'h01;
                if (half_q == mii_port_pkg::MDC_HALF_LAST) begin
                    half_d = '0;
                    if (!mdc_o) begin
                        mdc_d = 1'b1;
                    end else begin
                        // sample late in the high phase, the phy drives after the rise
                        if (read_q && bit_q >= mii_port_pkg::MGMT_DATA_BIT) begin
                            rdata_d = {rdata_o[14:0], mdio_in_i};
                        end
                        mdc_d = 1'b0;
                        if (bit_q == mii_port_pkg::MGMT_LAST_BIT) begin
                            done_d  = 1'b1;
                            busy_d  = 1'b0;
                            mdio_d  = 1'b0;
                            oe_n_d  = 1'b1;
                            state_d = mii_port_pkg::MGMT_IDLE;
                        end else begin
                            bit_d   = bit_q + 6'h01;
                            shift_d = {shift_q[62:0], 1'b0};
                            mdio_d  = shift_q[62];
                            oe_n_d  = read_q && (bit_d >= mii_port_pkg::MGMT_TA_BIT);
                        end
                    end
                end
            end
            default: begin
                state_d = mii_port_pkg::MGMT_IDLE;
            end
        endcase
        // port deselected: stop at once, release mdio, park mdc low
        if (!enable_i) begin
            state_d = mii_port_pkg::MGMT_IDLE;
            busy_d  = 1'b0;
            done_d  = 1'b0;
            mdio_d  = 1'b0;
            oe_n_d  = 1'b1;
            mdc_d   = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q     <= mii_port_pkg::MGMT_IDLE;
            half_q      <= '0;
            bit_q       <= '0;
            shift_q     <= '0;
            read_q      <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            mdio_o      <= 1'b0;
            mdio_oe_n_o <= 1'b1;
            mdc_o       <= 1'b0;
            rdata_o     <= '0;
        end else if (ce_i) begin
            state_q     <= state_d;
            half_q      <= half_d;
            bit_q       <= bit_d;
            shift_q     <= shift_d;
            read_q      <= read_d;
            busy_o      <= busy_d;
            done_o      <= done_d;
            mdio_o      <= mdio_d;
            mdio_oe_n_o <= oe_n_d;
            mdc_o       <= mdc_d;
            rdata_o     <= rdata_d;
        end
    end
endmodule : mgmt_serial

// ==== hw/external_mii_smi_port.sv ====
// external mii data port and serial management port, mac side
`timescale 1ns/100ps
module external_mii_smi_port (
    // system clock, reset, clock enable
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    // configuration levels
    input  wire logic                    int_phy_select_i,
    input  wire logic                    mgmt_port_select_i,
    // transmit user side, tx_clk_i domain
    input  wire logic                    tx_valid_i,
    input  wire logic [3:0]              tx_nibble_i,
    output logic                         tx_collision_o,
    // receive user side, rx_clk_i domain
    output logic                         rx_valid_o,
    output logic [3:0]                   rx_nibble_o,
    output logic                         rx_frame_end_o,
    output logic                         rx_frame_err_o,
    // medium status and strap, mclk_i domain
    output logic                         collision_o,
    output logic                         carrier_sense_o,
    output logic                         external_phy_present_strap_o,
    // management command, mclk_i domain
    input  wire logic                    mgmt_start_i,
    input  wire mii_port_pkg::mgmt_cmd_t mgmt_cmd_i,
    output logic                         mgmt_busy_o,
    output logic                         mgmt_done_o,
    output logic [15:0]                  mgmt_rdata_o,
    // mii transmit pins
    input  wire logic                    tx_clk_i,
    output logic [3:0]                   txd_o,
    output logic                         tx_en_o,
    // mii receive pins
    input  wire logic                    rx_clk_i,
    input  wire logic [3:0]              rxd_i,
    input  wire logic                    rx_dv_i,
    input  wire logic                    rx_er_i,
    input  wire logic                    col_i,
    input  wire logic                    crs_i,
    // management pins
    input  wire logic                    mdio_i,
    output logic                         mdio_o,
    output logic                         mdio_oe_n_o,
    output logic                         mdc_o
);
    // ------------
    // transmit domain, launched on the phy transmit clock
    // ------------
    logic                  tx_rst_n;
    logic                  tx_ce;
    logic                  tx_int_sel;
    logic                  tx_col;
    mii_port_pkg::mii_tx_t tx_q, tx_d;
    logic                  tx_col_d;

    // reset, enable and the internal phy select come from mclk logic, so they cross as levels
    sync_2ff #(
        .WIDTH   (4)
    ) u_tx_sync (
        .clk_i   (tx_clk_i),
        .async_i ({rst_n_i, ce_i, int_phy_select_i, col_i}),
        .sync_o  ({tx_rst_n, tx_ce, tx_int_sel, tx_col})
    );

    always_comb begin
        tx_d      = mii_port_pkg::TX_IDLE;
        tx_col_d  = tx_col;
        if (!tx_int_sel && tx_valid_i) begin
            tx_d.en   = 1'b1;
            tx_d.data = tx_nibble_i;
        end
        // internal phy owns the mac: pins stay quiet
        if (tx_int_sel) begin
            tx_d.en   = 1'b0;
            tx_d.data = '0;
        end
    end

    always_ff @(posedge tx_clk_i) begin
        if (!tx_rst_n) begin
            tx_q           <= mii_port_pkg::TX_IDLE;
            tx_collision_o <= 1'b0;
        end else if (tx_ce) begin
            tx_q           <= tx_d;
            tx_collision_o <= tx_col_d;
        end
    end

    assign txd_o   = tx_q.data;
    assign tx_en_o = tx_q.en;

    // ------------
    // receive domain, sampled on the phy receive clock
    // ------------
    logic                  rx_rst_n;
    logic                  rx_ce;
    mii_port_pkg::mii_rx_t rx_pin;
    mii_port_pkg::mii_rx_t rx_s1_q;
    mii_port_pkg::mii_rx_t rx_s2_q;
    logic                  rx_in_frame_q, rx_in_frame_d;
    logic                  rx_err_q, rx_err_d;
    logic                  rx_valid_d;
    logic [3:0]            rx_nibble_d;
    logic                  rx_end_d;
    logic                  rx_frame_err_d;

    sync_2ff #(
        .WIDTH   (2)
    ) u_rx_sync (
        .clk_i   (rx_clk_i),
        .async_i ({rst_n_i, ce_i}),
        .sync_o  ({rx_rst_n, rx_ce})
    );

    assign rx_pin.dv   = rx_dv_i;
    assign rx_pin.er   = rx_er_i;
    assign rx_pin.data = rxd_i;

    // two register stages ahead of any decision on the pins
    always_ff @(posedge rx_clk_i) begin
        if (!rx_rst_n) begin
            rx_s1_q <= mii_port_pkg::RX_IDLE;
            rx_s2_q <= mii_port_pkg::RX_IDLE;
        end else if (rx_ce) begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_comb begin
        rx_in_frame_d  = rx_s2_q.dv;
        rx_err_d       = rx_err_q;
        rx_valid_d     = rx_s2_q.dv;
        rx_nibble_d    = rx_s2_q.dv ? rx_s2_q.data : 4'h0;
        rx_end_d       = 1'b0;
        rx_frame_err_d = rx_frame_err_o;
        // a new frame starts clean; errors outside a frame are not ours
        if (rx_s2_q.dv && !rx_in_frame_q) begin
            rx_err_d = rx_s2_q.er;
        end else if (rx_s2_q.dv && rx_s2_q.er) begin
            rx_err_d = 1'b1;
        end
        if (rx_in_frame_q && !rx_s2_q.dv) begin
            rx_end_d       = 1'b1;
            rx_frame_err_d = rx_err_q;
        end
    end

    always_ff @(posedge rx_clk_i) begin
        if (!rx_rst_n) begin
            rx_in_frame_q  <= 1'b0;
            rx_err_q       <= 1'b0;
            rx_valid_o     <= 1'b0;
            rx_nibble_o    <= 4'h0;
            rx_frame_end_o <= 1'b0;
            rx_frame_err_o <= 1'b0;
        end else if (rx_ce) begin
            rx_in_frame_q  <= rx_in_frame_d;
            rx_err_q       <= rx_err_d;
            rx_valid_o     <= rx_valid_d;
            rx_nibble_o    <= rx_nibble_d;
            rx_frame_end_o <= rx_end_d;
            rx_frame_err_o <= rx_frame_err_d;
        end
    end

    // ------------
    // medium status and management pin input, mclk domain
    // ------------
    logic m_col;
    logic m_crs;
    logic m_mdio;
    logic col_d;
    logic crs_d;

    sync_2ff #(
        .WIDTH   (3)
    ) u_m_sync (
        .clk_i   (mclk_i),
        .async_i ({col_i, crs_i, mdio_i}),
        .sync_o  ({m_col, m_crs, m_mdio})
    );

    always_comb begin
        col_d = m_col;
        crs_d = m_crs;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            collision_o     <= 1'b0;
            carrier_sense_o <= 1'b0;
        end else if (ce_i) begin
            collision_o     <= col_d;
            carrier_sense_o <= crs_d;
        end
    end

    // ------------
    // strap capture after reset release
    // ------------
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic       strap_done_q, strap_done_d;
    logic       strap_d;

    // mdio stays released until the capture, so the pin shows the strap
    always_comb begin
        strap_cnt_d  = strap_cnt_q;
        strap_done_d = strap_done_q;
        strap_d      = external_phy_present_strap_o;
        if (!strap_done_q) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
            if (strap_cnt_q == mii_port_pkg::STRAP_SETTLE_LAST) begin
                strap_done_d = 1'b1;
                strap_d      = m_mdio;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            strap_cnt_q                  <= 2'h0;
            strap_done_q                 <= 1'b0;
            external_phy_present_strap_o <= 1'b0;
        end else if (ce_i) begin
            strap_cnt_q                  <= strap_cnt_d;
            strap_done_q                 <= strap_done_d;
            external_phy_present_strap_o <= strap_d;
        end
    end

    // ------------
    // management engine
    // ------------
    logic mgmt_enable;

    assign mgmt_enable = mgmt_port_select_i && strap_done_q;

    mgmt_serial u_mgmt (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .enable_i    (mgmt_enable),
        .start_i     (mgmt_start_i),
        .cmd_i       (mgmt_cmd_i),
        .busy_o      (mgmt_busy_o),
        .done_o      (mgmt_done_o),
        .rdata_o     (mgmt_rdata_o),
        .mdio_in_i   (m_mdio),
        .mdio_o      (mdio_o),
        .mdio_oe_n_o (mdio_oe_n_o),
        .mdc_o       (mdc_o)
    );

endmodule : external_mii_smi_port

// ==== bench/mii_port_props.sv ====
// assertion checker for the external mii and management port
`timescale 1ns/100ps
module mii_port_props (
    // system side
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       ce_i,
    input wire logic       int_phy_select_i,
    input wire logic       mgmt_port_select_i,
    input wire logic       mgmt_start_i,
    input wire logic       mgmt_busy_o,
    input wire logic       mgmt_done_o,
    // link side
    input wire logic       tx_clk_i,
    input wire logic       tx_valid_i,
    input wire logic [3:0] tx_nibble_i,
    input wire logic [3:0] txd_o,
    input wire logic       tx_en_o,
    input wire logic       rx_clk_i,
    input wire logic [3:0] rxd_i,
    input wire logic       rx_dv_i,
    input wire logic       rx_valid_o,
    input wire logic [3:0] rx_nibble_o,
    input wire logic       col_i,
    input wire logic       crs_i,
    input wire logic       collision_o,
    input wire logic       carrier_sense_o,
    // management pins
    input wire logic       mdio_oe_n_o,
    input wire logic       mdc_o
);
    // counts freeze with ce, as the design does
    logic [11:0] hi_q, hi_d, bsy_q, bsy_d;
    always_comb begin
        hi_d  = mdc_o ? hi_q + 12'(ce_i) : 12'h0;
        bsy_d = mgmt_busy_o ? bsy_q + 12'(ce_i) : 12'h0;
    end
    always_ff @(posedge mclk_i) begin
        hi_q  <= hi_d;
        bsy_q <= bsy_d;
    end
    sequence s_taken;
        $past(mgmt_start_i && mgmt_port_select_i && ce_i);
    endsequence
    sequence s_done_ok;
        !mgmt_busy_o && bsy_q == 12'hc80 ##1 !mgmt_done_o;
    endsequence
    property p_busy_rise;
        @(posedge mclk_i) disable iff (!rst_n_i) $rose(mgmt_busy_o) |-> s_taken;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
    property p_frame_len;
        @(posedge mclk_i) disable iff (!rst_n_i) mgmt_done_o |-> s_done_ok;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length");
    property p_mdc_high;
        @(posedge mclk_i) disable iff (!rst_n_i)
            $fell(mdc_o) && $past(mgmt_port_select_i) |-> hi_q == 12'h019;
    endproperty
    a_mdc_high: assert property (p_mdc_high) else $error("mdc high phase");
    property p_sel_off;
        @(posedge mclk_i) disable iff (!rst_n_i)
            !mgmt_port_select_i |=> !mdc_o && mdio_oe_n_o && !mgmt_busy_o;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("port not parked");
    property p_oe_busy;
        @(posedge mclk_i) disable iff (!rst_n_i) !mdio_oe_n_o |-> mgmt_busy_o;
    endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("mdio driven idle");
    property p_status;
        @(posedge mclk_i) disable iff (!rst_n_i)
            carrier_sense_o == $past(crs_i, 3) && collision_o == $past(col_i, 3);
    endproperty
    a_status: assert property (p_status) else $error("status lag");
    property p_tx_int;
        @(posedge tx_clk_i) disable iff (!rst_n_i)
            int_phy_select_i [*4] |-> txd_o == 4'h0 && !tx_en_o;
    endproperty
    a_tx_int: assert property (p_tx_int) else $error("tx not idle");
    property p_tx_path;
        @(posedge tx_clk_i) disable iff (!rst_n_i)
            !int_phy_select_i [*4] |-> tx_en_o == $past(tx_valid_i)
                && txd_o == ($past(tx_valid_i) ? $past(tx_nibble_i) : 4'h0);
    endproperty
    a_tx_path: assert property (p_tx_path) else $error("tx path");
    property p_rx_path;
        @(posedge rx_clk_i) disable iff (!rst_n_i)
            rx_valid_o == $past(rx_dv_i, 3)
                && rx_nibble_o == ($past(rx_dv_i, 3) ? $past(rxd_i, 3) : 4'h0);
    endproperty
    a_rx_path: assert property (p_rx_path) else $error("rx path");
endmodule : mii_port_props

bind external_mii_smi_port mii_port_props u_props (.*);

// ==== bench/phy_model.sv ====
// behavioural external phy: link clocks, receive frames, status, management
`timescale 1ns/100ps
module phy_model (
    // link pins
    output logic       tx_clk_o,
    output logic       rx_clk_o,
    output logic [3:0] rxd_o,
    output logic       rx_dv_o,
    output logic       rx_er_o,
    output logic       col_o,
    output logic       crs_o,
    // management pins, line level resolved here
    input  wire logic  mdc_i,
    input  wire logic  mdio_dev_i,
    input  wire logic  mdio_oe_n_i,
    input  wire logic  strap_i,
    output logic       mdio_line_o
);
    logic [15:0] rd_data = 16'h0;
    logic [63:0] cap = 64'h0;
    logic        drv_en = 1'b0;
    logic        drv = 1'b0;
    logic        is_rd = 1'b0;
    int          cnt = 0;
    realtime     last = 0.0;
    initial {tx_clk_o, rx_clk_o, rxd_o, rx_dv_o, rx_er_o, col_o, crs_o} = '0;
    // free-running link clocks, unrelated phases
    initial #3.3 forever #16 tx_clk_o = ~tx_clk_o;
    initial #11.1 forever #16 rx_clk_o = ~rx_clk_o;
    // released line falls back to the strap resistor level
    assign mdio_line_o = !mdio_oe_n_i ? mdio_dev_i : drv_en ? drv : strap_i;
    always @(posedge mdc_i) begin
        if (cnt == 64 || $realtime - last > 1000.0) cnt = 0;
        last = $realtime;
        if (cnt == 35) is_rd = cap[0] & ~mdio_line_o;
        cap = {cap[62:0], mdio_line_o};
        cnt = cnt + 1;
    end
    // drive on the fall, settled before the next rise
    always @(negedge mdc_i) begin
        drv_en = is_rd && cnt >= 47 && cnt <= 63;
        drv = (cnt == 47) ? 1'b0 : rd_data[(63 - cnt) & 15];
    end
    task automatic send_frame(input int n, input int er_at, input logic [3:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge rx_clk_o);
            rx_dv_o <= 1'b1;
            crs_o <= 1'b1;
            rxd_o <= base + 4'(i);
            rx_er_o <= (i == er_at);
        end
        @(posedge rx_clk_o);
        rx_dv_o <= 1'b0;
        crs_o <= 1'b0;
        rxd_o <= ~rxd_o;
        rx_er_o <= (er_at == n);
        @(posedge rx_clk_o);
        rx_er_o <= 1'b0;
    endtask : send_frame
    task automatic collide(input int n);
        @(posedge rx_clk_o);
        col_o <= 1'b1;
        repeat (n) @(posedge rx_clk_o);
        col_o <= 1'b0;
    endtask : collide
endmodule : phy_model

// ==== bench/testbench.sv ====
// self-checking bench for the external mii and management port
`timescale 1ns/100ps
module testbench;
    logic                    mclk_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    logic                    ce_i = 1'b1;
    logic                    int_phy_select_i = 1'b0;
    logic                    mgmt_port_select_i = 1'b1;
    logic                    tx_valid_i = 1'b0;
    logic [3:0]              tx_nibble_i = 4'h0;
    logic                    mgmt_start_i = 1'b0;
    mii_port_pkg::mgmt_cmd_t mgmt_cmd_i = '0;
    logic                    phy_strap = 1'b1;
    logic tx_collision_o, rx_valid_o, rx_frame_end_o, rx_frame_err_o, collision_o;
    logic carrier_sense_o, external_phy_present_strap_o, mgmt_busy_o, mgmt_done_o;
    logic tx_clk_i, rx_clk_i, tx_en_o, rx_dv_i, rx_er_i, col_i, crs_i;
    logic mdio_i, mdio_o, mdio_oe_n_o, mdc_o;
    logic [3:0]  rx_nibble_o, txd_o, rxd_i, b;
    logic [15:0] mgmt_rdata_o;
    logic [3:0]  tx_q[$], rx_q[$];
    logic        err_q[$];
    logic [16:0] mg_q[$];
    logic [63:0] fr_q[$];
    logic [31:0] lfsr = 32'hc6dd;
    int          num_errors = 0;
    int          check_count = 0;

    always #4 mclk_i = ~mclk_i;

    external_mii_smi_port u_dut (.mclk_i, .rst_n_i, .ce_i, .int_phy_select_i,
        .mgmt_port_select_i, .tx_valid_i, .tx_nibble_i, .tx_collision_o, .rx_valid_o,
        .rx_nibble_o, .rx_frame_end_o, .rx_frame_err_o, .collision_o, .carrier_sense_o,
        .external_phy_present_strap_o, .mgmt_start_i, .mgmt_cmd_i, .mgmt_busy_o,
        .mgmt_done_o, .mgmt_rdata_o, .tx_clk_i, .txd_o, .tx_en_o, .rx_clk_i, .rxd_i,
        .rx_dv_i, .rx_er_i, .col_i, .crs_i, .mdio_i, .mdio_o, .mdio_oe_n_o, .mdc_o);
    phy_model u_phy (.tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i), .rxd_o(rxd_i),
        .rx_dv_o(rx_dv_i), .rx_er_o(rx_er_i), .col_o(col_i), .crs_o(crs_i), .mdc_i(mdc_o),
        .mdio_dev_i(mdio_o), .mdio_oe_n_i(mdio_oe_n_o), .strap_i(phy_strap),
        .mdio_line_o(mdio_i));

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // call at a falling edge; note=0: frame will not complete
    task automatic mgmt(input logic wr, input logic [15:0] d, input logic note);
        logic [9:0] ad;
        ad = 10'(rnd());
        u_phy.rd_data = d;
        if (note) mg_q.push_back({~wr, d});
        if (note) fr_q.push_back(wr ? {32'hffffffff, 4'h5, ad, 2'h2, d}
                                    : {32'hffffffff, 4'h6, ad, phy_strap, 1'b0, d});
        mgmt_cmd_i = {wr, ad, wr ? d : ~d};
        mgmt_start_i = 1'b1;
        @(negedge mclk_i);
        mgmt_start_i = 1'b0;
        if (note) chk(mgmt_busy_o, 1'b1);
    endtask : mgmt
    task automatic wait_idle();
        int k;
        k = 0;
        while (mgmt_busy_o !== 1'b0 && k < 4000) begin
            @(negedge mclk_i);
            k++;
        end
        chk(k < 4000, 1'b1);
    endtask : wait_idle
    task automatic tx_burst(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge tx_clk_i);
            tx_valid_i = 1'b1;
            tx_nibble_i = 4'(rnd());
            if (!int_phy_select_i) tx_q.push_back(tx_nibble_i);
        end
        @(negedge tx_clk_i);
        tx_valid_i = 1'b0;
    endtask : tx_burst

    always @(posedge tx_clk_i)
        if (tx_en_o === 1'b1) chk(txd_o, tx_q.size() > 0 ? tx_q.pop_front() : 4'hx);
    always @(posedge rx_clk_i) begin
        if (rx_valid_o === 1'b1) chk(rx_nibble_o, rx_q.size() ? rx_q.pop_front() : 4'hx);
        if (rx_frame_end_o === 1'b1) chk(rx_frame_err_o, err_q.pop_front());
    end
    always @(posedge mclk_i) begin
        if (mgmt_done_o === 1'b1) begin
            chk(u_phy.cap, fr_q.size() > 0 ? fr_q.pop_front() : 64'hx);
            if (mg_q.size() > 0 && mg_q[0][16]) chk(mgmt_rdata_o, mg_q[0][15:0]);
            if (mg_q.size() > 0) void'(mg_q.pop_front());
        end
    end

    initial begin
        repeat (12) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        chk(external_phy_present_strap_o, 1'b1);
        mgmt(1'b1, 16'(rnd()), 1'b1);
        repeat (300) @(negedge mclk_i);
        mgmt(1'b0, 16'hffff, 1'b0);
        wait_idle();
        mgmt(1'b0, 16'(rnd()), 1'b1);
        wait_idle();
        mgmt(1'b1, 16'h0, 1'b0);
        repeat (500) @(negedge mclk_i);
        mgmt_port_select_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk({mgmt_busy_o, mdio_oe_n_o, mdc_o}, 3'h2);
        repeat (200) @(negedge mclk_i);
        mgmt_port_select_i = 1'b1;
        ce_i = 1'b0;
        mgmt_start_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        mgmt_start_i = 1'b0;
        ce_i = 1'b1;
        chk(mgmt_busy_o, 1'b0);
        // link domains see ce through two flops: let the freeze pass first
        repeat (16) @(negedge mclk_i);
        fork
            tx_burst(24);
            for (int k = 0; k < 3; k++) begin
                b = 4'(rnd());
                for (int i = 0; i < 6; i++) rx_q.push_back(b + 4'(i));
                err_q.push_back(k == 1);
                u_phy.send_frame(6, k == 0 ? -1 : k == 1 ? 2 : 6, b);
            end
            begin
                u_phy.collide(6);
                chk(tx_collision_o, 1'b1);
                repeat (5) @(negedge tx_clk_i);
                chk(tx_collision_o, 1'b0);
            end
        join
        int_phy_select_i = 1'b1;
        repeat (4) @(negedge tx_clk_i);
        tx_burst(8);
        int_phy_select_i = 1'b0;
        repeat (6) @(negedge tx_clk_i);
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        phy_strap = 1'b0;
        repeat (12) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        chk(external_phy_present_strap_o, 1'b0);
        chk(tx_q.size() + rx_q.size() + mg_q.size() + err_q.size() + fr_q.size(), 0);
        report_and_stop();
    end
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
